// file: logic/pss_device.sv
// Device end: power modes, start-up phases and interface detection
//
// Local design decisions: register access over Wishbone and the register addresses.
`timescale 1ns/1ps
module pss_device import pss_pkg::*; (
  // Clock and reset
  input wire logic clk_i,
  input wire logic rst_i,
  // Supply monitors and oscillator input
  input wire logic digital_supply_por_i,
  input wire logic analog_supply_por_i,
  input wire logic osc_input_pin_i,
  // Host parallel port
  pss_if.device bus,
  // Analog and pin controls
  output logic osc_enable_o,
  output logic current_sinks_on_o,
  output logic digital_clock_on_o,
  output logic receiver_on_o,
  output logic inputs_connected_o,
  output logic irq_oe_o,
  output logic signal_monitor_out_o,
  output logic antenna_drive_a_o,
  output logic antenna_drive_b_o,
  output logic osc_output_pin_o,
  output logic linear_addressing_o,
  output logic interface_detected_o,
  output logic [5:0] init_addr_o,
  output logic init_load_o
);
  typedef enum logic [2:0] {
    ST_HARD_PD = 3'b000,
    ST_RESET = 3'b001,
    ST_INIT = 3'b010,
    ST_RUN = 3'b011
  } phase_e;

  // Pin inputs from outside: three-stage synchronisers
  logic [2:0] pd_sync_q;
  logic [2:0] osc_sync_q;
  logic pd_level_q;
  logic osc_level_q;
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      pd_sync_q <= 3'h7;
      osc_sync_q <= 3'h0;
      pd_level_q <= 1'b1;
      osc_level_q <= 1'b0;
    end else begin
      pd_sync_q <= {pd_sync_q[1:0], bus.hard_soft_sleep_bit_pin};
      osc_sync_q <= {osc_sync_q[1:0], osc_input_pin_i};
      if (pd_sync_q[1] == pd_sync_q[2]) pd_level_q <= pd_sync_q[2];
      if (osc_sync_q[1] == osc_sync_q[2]) osc_level_q <= osc_sync_q[2];
    end
  end

  logic osc_prev_q;
  logic osc_rise;
  logic hard_pd;
  assign osc_rise = osc_level_q & ~osc_prev_q;
  assign hard_pd = pd_level_q | digital_supply_por_i | analog_supply_por_i;

  // Sequencer and control state
  phase_e phase_q, phase_d;
  logic [9:0] cnt_q, cnt_d;
  logic sleep_sw_q, sleep_sw_d;
  logic sleep_rd_q, sleep_rd_d;
  logic stby_sw_q, stby_sw_d;
  logic stby_rd_q, stby_rd_d;
  logic [9:0] sleep_cnt_q, sleep_cnt_d;
  logic [2:0] stby_cnt_q, stby_cnt_d;
  logic auto_gate_q, auto_gate_d;
  logic [5:0] cmd_q, cmd_d;
  logic [7:0] page_q, page_d;
  logic detected_q, detected_d;
  logic linear_q, linear_d;
  logic wr_q;
  logic wr_strobe;
  assign wr_strobe = bus.cs & bus.wr & ~wr_q;

  // Next state of phases, mode bits and port registers
  always_comb begin
    phase_d = phase_q;
    cnt_d = cnt_q;
    sleep_sw_d = sleep_sw_q;
    sleep_rd_d = sleep_rd_q;
    stby_sw_d = stby_sw_q;
    stby_rd_d = stby_rd_q;
    sleep_cnt_d = sleep_cnt_q;
    stby_cnt_d = stby_cnt_q;
    auto_gate_d = auto_gate_q;
    cmd_d = cmd_q;
    page_d = page_q;
    detected_d = detected_q;
    linear_d = linear_q;
    case (phase_q)
      ST_HARD_PD: begin
        cmd_d = CMD_STARTUP;
        if (!hard_pd) begin
          phase_d = ST_RESET;
          cnt_d = 10'(RESET_PHASE_CYCLES - 1);
        end
      end
      ST_RESET: begin
        // Reset values loaded during this phase
        sleep_sw_d = 1'b0;
        sleep_rd_d = 1'b0;
        stby_sw_d = 1'b0;
        stby_rd_d = 1'b0;
        auto_gate_d = 1'b1;
        page_d = PAGE_DETECT;
        detected_d = 1'b0;
        linear_d = 1'b0;
        if (cnt_q == 10'h0) begin
          phase_d = ST_INIT;
          cnt_d = 10'(INIT_PHASE_CYCLES - 1);
        end else begin
          cnt_d = cnt_q - 10'h1;
        end
      end
      ST_INIT: begin
        if (cnt_q == 10'h0) begin
          phase_d = ST_RUN;
          cmd_d = CMD_IDLE;
        end else begin
          cnt_d = cnt_q - 10'h1;
        end
      end
      ST_RUN: begin
        // Sleep exit: bit reads set until the count expires
        if (sleep_rd_q && !sleep_sw_q) begin
          if (sleep_cnt_q == 10'h0) sleep_rd_d = 1'b0;
          else sleep_cnt_d = sleep_cnt_q - 10'h1;
        end
        // Standby exit counts oscillator edges
        if (stby_rd_q && !stby_sw_q && osc_rise) begin
          if (stby_cnt_q == 3'h1) stby_rd_d = 1'b0;
          else stby_cnt_d = stby_cnt_q - 3'h1;
        end
        if (wr_strobe) begin
          case (bus.addr)
            ADDR_CONTROL: begin
              sleep_sw_d = bus.wdata[CTRL_SLEEP_BIT];
              stby_sw_d = bus.wdata[CTRL_STANDBY_BIT];
              if (bus.wdata[CTRL_SLEEP_BIT]) sleep_rd_d = 1'b1;
              if (bus.wdata[CTRL_STANDBY_BIT]) stby_rd_d = 1'b1;
              sleep_cnt_d = 10'(SLEEP_EXIT_CYCLES - 1);
              stby_cnt_d = 3'(STANDBY_EXIT_OSC_EDGES);
            end
            ADDR_RX_CTRL: auto_gate_d = bus.wdata[RXCTRL_AUTO_GATE_BIT];
            ADDR_PAGE: begin
              page_d = bus.wdata;
              if (bus.wdata == PAGE_DETECT) begin
                detected_d = 1'b1;
                cmd_d = CMD_IDLE;
              end else if (bus.wdata == PAGE_LINEAR && detected_q) begin
                linear_d = 1'b1;
              end
            end
            default: ;
          endcase
        end
      end
      default: phase_d = ST_HARD_PD;
    endcase
    if (hard_pd) begin
      phase_d = ST_HARD_PD;
      sleep_sw_d = 1'b0;
      sleep_rd_d = 1'b0;
      stby_sw_d = 1'b0;
      stby_rd_d = 1'b0;
    end
  end

  // State registers
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      phase_q <= ST_HARD_PD;
      cnt_q <= 10'h0;
      sleep_sw_q <= 1'b0;
      sleep_rd_q <= 1'b0;
      stby_sw_q <= 1'b0;
      stby_rd_q <= 1'b0;
      sleep_cnt_q <= 10'h0;
      stby_cnt_q <= 3'h0;
      auto_gate_q <= 1'b1;
      cmd_q <= CMD_STARTUP;
      page_q <= PAGE_DETECT;
      detected_q <= 1'b0;
      linear_q <= 1'b0;
      wr_q <= 1'b0;
      osc_prev_q <= 1'b0;
    end else begin
      phase_q <= phase_d;
      cnt_q <= cnt_d;
      sleep_sw_q <= sleep_sw_d;
      sleep_rd_q <= sleep_rd_d;
      stby_sw_q <= stby_sw_d;
      stby_rd_q <= stby_rd_d;
      sleep_cnt_q <= sleep_cnt_d;
      stby_cnt_q <= stby_cnt_d;
      auto_gate_q <= auto_gate_d;
      cmd_q <= cmd_d;
      page_q <= page_d;
      detected_q <= detected_d;
      linear_q <= linear_d;
      wr_q <= bus.cs & bus.wr;
      osc_prev_q <= osc_level_q;
    end
  end

  // Read data mux, registered
  logic [7:0] rdata_d;
  always_comb begin
    case (bus.addr)
      ADDR_PAGE: rdata_d = page_q;
      ADDR_COMMAND: rdata_d = {2'b00, cmd_q};
      ADDR_CONTROL: begin
        rdata_d = 8'h00;
        rdata_d[CTRL_SLEEP_BIT] = sleep_rd_q;
        rdata_d[CTRL_STANDBY_BIT] = stby_rd_q;
      end
      ADDR_RX_CTRL: rdata_d = {4'h0, auto_gate_q, 3'h0};
      default: rdata_d = 8'h00;
    endcase
  end

  // Pin and analog control outputs, all registered
  logic pd_now;
  logic running;
  assign pd_now = (phase_d == ST_HARD_PD);
  assign running = (phase_d == ST_RUN);
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      bus.rdata <= 8'h00;
      osc_enable_o <= 1'b0;
      current_sinks_on_o <= 1'b0;
      digital_clock_on_o <= 1'b0;
      receiver_on_o <= 1'b0;
      inputs_connected_o <= 1'b0;
      irq_oe_o <= 1'b0;
      signal_monitor_out_o <= 1'b0;
      antenna_drive_a_o <= 1'b1;
      antenna_drive_b_o <= 1'b0;
      osc_output_pin_o <= 1'b1;
      linear_addressing_o <= 1'b0;
      interface_detected_o <= 1'b0;
      init_addr_o <= ADDR_INIT_FIRST;
      init_load_o <= 1'b0;
    end else begin
      bus.rdata <= pd_now ? 8'h00 : rdata_d;
      osc_enable_o <= !pd_now && !sleep_rd_d;
      current_sinks_on_o <= !pd_now && !sleep_rd_d && !stby_rd_d;
      digital_clock_on_o <= !pd_now && !stby_rd_d;
      receiver_on_o <= running && !sleep_rd_d && !stby_rd_d &&
        (!auto_gate_d || bus.rx_window);
      inputs_connected_o <= !pd_now;
      irq_oe_o <= !pd_now;
      if (pd_now) begin
        signal_monitor_out_o <= 1'b0;
        antenna_drive_a_o <= 1'b1;
        antenna_drive_b_o <= 1'b0;
        osc_output_pin_o <= 1'b1;
      end else if (!sleep_rd_d && !stby_rd_d) begin
        signal_monitor_out_o <= 1'b0;
        antenna_drive_a_o <= 1'b0;
        antenna_drive_b_o <= 1'b0;
        osc_output_pin_o <= osc_level_q;
      end
      linear_addressing_o <= linear_d;
      interface_detected_o <= detected_d;
      // Copy pulse stands with the address it loads, one pulse per address
      if (phase_q != ST_INIT) begin
        init_load_o <= 1'b0;
        init_addr_o <= ADDR_INIT_FIRST;
      end else if (init_load_o) begin
        init_load_o <= (init_addr_o != ADDR_INIT_LAST);
        init_addr_o <= init_addr_o + 6'h1;
      end else if (init_addr_o == ADDR_INIT_FIRST) init_load_o <= 1'b1;
    end
  end
endmodule

// file: logic/pss_pkg.sv
// Package: constants shared by the power/start-up sequencer and its host end
package pss_pkg;
  // Clock and timing
  localparam int CLK_HZ = 10000000;
  localparam int RESET_PHASE_CYCLES = 512;
  localparam int INIT_PHASE_CYCLES = 128;
  localparam int SLEEP_EXIT_CYCLES = 512;
  localparam int STANDBY_EXIT_OSC_EDGES = 4;
  localparam int HARD_PD_MIN_US = 100;
  localparam int HARD_PD_MIN_CYCLES = (HARD_PD_MIN_US * (CLK_HZ / 1000000));
  localparam int POLL_SETTLE_CYCLES = 16;
  // Device register addresses on the parallel port
  localparam logic [5:0] ADDR_PAGE = 6'h00;
  localparam logic [5:0] ADDR_COMMAND = 6'h01;
  localparam logic [5:0] ADDR_CONTROL = 6'h09;
  localparam logic [5:0] ADDR_RX_CTRL = 6'h1f;
  localparam logic [5:0] ADDR_INIT_FIRST = 6'h10;
  localparam logic [5:0] ADDR_INIT_LAST = 6'h2f;
  // Control register bits
  localparam int CTRL_SLEEP_BIT = 4;
  localparam int CTRL_STANDBY_BIT = 5;
  localparam int RXCTRL_AUTO_GATE_BIT = 3;
  // Command and page values
  localparam logic [5:0] CMD_STARTUP = 6'h3f;
  localparam logic [5:0] CMD_IDLE = 6'h00;
  localparam logic [7:0] PAGE_DETECT = 8'h80;
  localparam logic [7:0] PAGE_LINEAR = 8'h00;
  // Host-side Wishbone register offsets
  localparam logic [3:0] WB_HCTRL = 4'h0;
  localparam logic [3:0] WB_HSTAT = 4'h4;
  localparam logic [3:0] WB_HCFG = 4'h8;
endpackage

// file: logic/pss_if.sv
// Interface: parallel port and power pins between device and host
`timescale 1ns/1ps
interface pss_if;
  logic hard_soft_sleep_bit_pin;
  logic cs;
  logic wr;
  logic [5:0] addr;
  logic [7:0] wdata;
  logic [7:0] rdata;
  logic rx_window;
  modport device (
    input hard_soft_sleep_bit_pin, cs, wr, addr, wdata, rx_window,
    output rdata
  );
  modport host (
    output hard_soft_sleep_bit_pin, cs, wr, addr, wdata, rx_window,
    input rdata
  );
endinterface

// file: logic/pss_host.sv
// Host end: power-down pulse and interface-detection handshake, Wishbone controlled
`timescale 1ns/1ps
module pss_host import pss_pkg::*; (
  // Clock and reset
  input wire logic clk_i,
  input wire logic rst_i,
  // Wishbone slave
  input wire logic cyc_i,
  input wire logic stb_i,
  input wire logic we_i,
  input wire logic [3:0] adr_i,
  input wire logic [3:0] sel_i,
  input wire logic [31:0] dat_i,
  output logic [31:0] dat_o,
  output logic ack_o,
  // Device link
  pss_if.host bus
);
  typedef enum logic [2:0] {
    H_IDLE = 3'b000,
    H_PD = 3'b001,
    H_POLL = 3'b010,
    H_DETECT = 3'b011,
    H_CHECK = 3'b100,
    H_LINEAR = 3'b101,
    H_DONE = 3'b110,
    H_FAIL = 3'b111
  } hstate_e;

  hstate_e st_q, st_d;
  logic [10:0] cnt_q, cnt_d;
  logic [1:0] ph_q, ph_d;
  logic pd_q, pd_d;
  logic cs_q, cs_d;
  logic wr_q, wr_d;
  logic [5:0] addr_q, addr_d;
  logic [7:0] wdata_q, wdata_d;
  logic rxw_q, rxw_d;
  logic start_q, start_d;
  logic ack_d;
  logic [31:0] dat_d;

  // Sequence: pulse power-down, poll idle, detect, check, go linear
  always_comb begin
    st_d = st_q;
    cnt_d = cnt_q;
    ph_d = ph_q;
    pd_d = pd_q;
    cs_d = 1'b0;
    wr_d = 1'b0;
    addr_d = addr_q;
    wdata_d = wdata_q;
    rxw_d = rxw_q;
    start_d = 1'b0;
    ack_d = cyc_i && stb_i && !ack_o;
    dat_d = 32'h0;
    if (ack_d && !we_i) begin
      if (adr_i == WB_HSTAT) dat_d = {29'h0, st_q};
      else if (adr_i == WB_HCFG) dat_d = {31'h0, rxw_q};
    end
    if (ack_d && we_i && sel_i[0]) begin
      if (adr_i == WB_HCTRL) start_d = dat_i[0];
      else if (adr_i == WB_HCFG) rxw_d = dat_i[0];
    end
    ph_d = ph_q + 2'h1;
    case (st_q)
      H_IDLE: if (start_q) begin
        st_d = H_PD;
        pd_d = 1'b1;
        cnt_d = 11'(HARD_PD_MIN_CYCLES);
      end
      H_PD: begin
        if (cnt_q == 11'h0) begin
          pd_d = 1'b0;
          st_d = H_POLL;
          ph_d = 2'h0;
          // Device still shows zero read data until its pin synchroniser sees the release
          cnt_d = 11'(POLL_SETTLE_CYCLES);
        end else cnt_d = cnt_q - 11'h1;
      end
      H_POLL, H_CHECK: begin
        addr_d = ADDR_COMMAND;
        cs_d = 1'b1;
        if (cnt_q != 11'h0) begin
          cnt_d = cnt_q - 11'h1;
        end else if (ph_q == 2'h3) begin
          if (bus.rdata[5:0] == CMD_IDLE) begin
            st_d = (st_q == H_POLL) ? H_DETECT : H_LINEAR;
          end else if (st_q == H_CHECK) st_d = H_FAIL;
        end
      end
      H_DETECT, H_LINEAR: begin
        addr_d = ADDR_PAGE;
        wdata_d = (st_q == H_DETECT) ? PAGE_DETECT : PAGE_LINEAR;
        cs_d = (ph_q != 2'h3);
        wr_d = (ph_q != 2'h3);
        if (ph_q == 2'h3) st_d = (st_q == H_DETECT) ? H_CHECK : H_DONE;
      end
      default: if (start_q) st_d = H_IDLE;
    endcase
  end

  // Registers
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      st_q <= H_IDLE;
      cnt_q <= 11'h0;
      ph_q <= 2'h0;
      pd_q <= 1'b0;
      cs_q <= 1'b0;
      wr_q <= 1'b0;
      addr_q <= 6'h0;
      wdata_q <= 8'h0;
      rxw_q <= 1'b0;
      start_q <= 1'b0;
      ack_o <= 1'b0;
      dat_o <= 32'h0;
    end else begin
      st_q <= st_d;
      cnt_q <= cnt_d;
      ph_q <= ph_d;
      pd_q <= pd_d;
      cs_q <= cs_d;
      wr_q <= wr_d;
      addr_q <= addr_d;
      wdata_q <= wdata_d;
      rxw_q <= rxw_d;
      start_q <= start_d;
      ack_o <= ack_d;
      dat_o <= dat_d;
    end
  end

  // Link drive
  assign bus.hard_soft_sleep_bit_pin = pd_q;
  assign bus.cs = cs_q;
  assign bus.wr = wr_q;
  assign bus.addr = addr_q;
  assign bus.wdata = wdata_q;
  assign bus.rx_window = rxw_q;
endmodule

// file: verification/pss_assertions.sv
// Checker: power-down, start-up and detection timing on the joined link
`timescale 1ns/1ps
module pss_assertions import pss_pkg::*; (
  // Clock and reset
  input wire logic clk_i,
  input wire logic rst_i,
  // Link signals
  input wire logic hard_soft_sleep_bit_pin,
  input wire logic cs,
  input wire logic wr,
  input wire logic [5:0] addr,
  input wire logic [7:0] wdata,
  input wire logic [7:0] rdata,
  input wire logic rx_window,
  // Device outputs
  input wire logic osc_enable_o,
  input wire logic current_sinks_on_o,
  input wire logic inputs_connected_o,
  input wire logic irq_oe_o,
  input wire logic signal_monitor_out_o,
  input wire logic antenna_drive_a_o,
  input wire logic antenna_drive_b_o,
  input wire logic osc_output_pin_o,
  input wire logic receiver_on_o,
  input wire logic linear_addressing_o,
  input wire logic interface_detected_o,
  input wire logic [5:0] init_addr_o,
  input wire logic init_load_o
);
  default clocking cb @(posedge clk_i);
  endclocking
  default disable iff (rst_i);
  logic [10:0] since_q;
  logic [10:0] since_d;
  logic [10:0] high_q;
  logic [10:0] high_d;
  // Cycles since power-down ended, and length of the current high pulse
  always_comb begin
    since_d = (hard_soft_sleep_bit_pin || since_q == 11'h7ff) ? (hard_soft_sleep_bit_pin ? 11'h000 : since_q)
      : since_q + 11'h001;
    high_d = !hard_soft_sleep_bit_pin ? 11'h000 : (high_q == 11'h7ff ? high_q : high_q + 11'h001);
  end
  // Helper counters restart with reset
  always_ff @(posedge clk_i) begin
    since_q <= rst_i ? 11'h000 : since_d;
    high_q <= rst_i ? 11'h000 : high_d;
  end
  sequence pd_held;
    hard_soft_sleep_bit_pin [*8];
  endsequence
  sequence page_wr(logic [7:0] v);
    $rose(cs && wr) && addr == ADDR_PAGE && wdata == v;
  endsequence
  chk_pd_rdata_zero: assert property (pd_held |-> rdata == 8'h00)
    else $error("read data not zero in power down");
  chk_pd_sinks_off: assert property (pd_held |-> !osc_enable_o && !current_sinks_on_o
    && !inputs_connected_o) else $error("oscillator or inputs alive in power down");
  chk_pd_pin_levels: assert property (pd_held |-> antenna_drive_a_o && !antenna_drive_b_o
    && osc_output_pin_o && !signal_monitor_out_o && !irq_oe_o) else $error("pin levels wrong");
  chk_pd_min_width: assert property ($fell(hard_soft_sleep_bit_pin) |-> high_q >= HARD_PD_MIN_CYCLES)
    else $error("power-down pulse too short");
  chk_reset_phase: assert property (init_load_o |-> since_q >= RESET_PHASE_CYCLES)
    else $error("copy started inside reset phase");
  chk_init_span: assert property (init_load_o |-> since_q <= RESET_PHASE_CYCLES
    + INIT_PHASE_CYCLES + 8 && init_addr_o >= ADDR_INIT_FIRST && init_addr_o <= ADDR_INIT_LAST)
    else $error("copy outside init window");
  chk_detect_flag: assert property (page_wr(PAGE_DETECT) |-> ##[1:8] interface_detected_o)
    else $error("detection flag not set");
  chk_linear_mode: assert property (page_wr(PAGE_LINEAR) ##0 interface_detected_o
    |-> ##[1:8] linear_addressing_o) else $error("linear addressing not entered");
  chk_rx_gating: assert property ((linear_addressing_o && rx_window) [*4] |-> receiver_on_o)
    else $error("receiver off in receive window");
endmodule

// file: verification/tb_power_startup_sequencer.sv
// Testbench: host sequence on one link, bench-driven device on the other
`timescale 1ns/1ps
module tb_power_startup_sequencer;
  import pss_pkg::*;
  logic clk_i = 1'b0;
  logic rst_i = 1'b1;
  logic cyc = 1'b0;
  logic stb = 1'b0;
  logic we = 1'b0;
  logic [3:0] adr = 4'h0;
  logic [31:0] dat_w = 32'h0;
  logic [31:0] dat_r;
  logic ack;
  logic por_d = 1'b0;
  logic por_a = 1'b0;
  logic osc = 1'b0;
  logic pd_b = 1'b0;
  logic osc_enable_o, current_sinks_on_o, inputs_connected_o, irq_oe_o, signal_monitor_out_o;
  logic antenna_drive_a_o, antenna_drive_b_o, osc_output_pin_o, receiver_on_o;
  logic linear_addressing_o, interface_detected_o, init_load_o;
  logic [5:0] init_addr_o;
  logic b_osc, b_sinks, b_dclk, b_rx, b_inp, b_lin, b_det, b_load;
  int fail_count = 0;
  int samples_checked = 0;
  int loads = 0;
  int cycles = 0;
  logic [31:0] q;
  pss_if pss_if_i ();
  pss_if pss_if_b_i ();
  assign pss_if_b_i.hard_soft_sleep_bit_pin = pd_b;
  // Clock of 100 ns
  always #50 clk_i = ~clk_i;
  pss_host pss_host_i (.clk_i(clk_i), .rst_i(rst_i), .cyc_i(cyc), .stb_i(stb), .we_i(we),
    .adr_i(adr), .sel_i(4'h1), .dat_i(dat_w), .dat_o(dat_r), .ack_o(ack), .bus(pss_if_i));
  pss_device pss_device_i (.clk_i(clk_i), .rst_i(rst_i), .digital_supply_por_i(1'b0),
    .analog_supply_por_i(1'b0), .osc_input_pin_i(osc), .bus(pss_if_i),
    .osc_enable_o(osc_enable_o), .current_sinks_on_o(current_sinks_on_o), .digital_clock_on_o(),
    .receiver_on_o(receiver_on_o), .inputs_connected_o(inputs_connected_o), .irq_oe_o(irq_oe_o),
    .signal_monitor_out_o(signal_monitor_out_o), .antenna_drive_a_o(antenna_drive_a_o),
    .antenna_drive_b_o(antenna_drive_b_o), .osc_output_pin_o(osc_output_pin_o),
    .linear_addressing_o(linear_addressing_o), .interface_detected_o(interface_detected_o),
    .init_addr_o(init_addr_o), .init_load_o(init_load_o));
  pss_device pss_device_b_i (.clk_i(clk_i), .rst_i(rst_i), .digital_supply_por_i(por_d),
    .analog_supply_por_i(por_a), .osc_input_pin_i(osc), .bus(pss_if_b_i),
    .osc_enable_o(b_osc), .current_sinks_on_o(b_sinks), .digital_clock_on_o(b_dclk),
    .receiver_on_o(b_rx), .inputs_connected_o(b_inp), .irq_oe_o(), .signal_monitor_out_o(),
    .antenna_drive_a_o(), .antenna_drive_b_o(), .osc_output_pin_o(),
    .linear_addressing_o(b_lin), .interface_detected_o(b_det), .init_addr_o(),
    .init_load_o(b_load));
  pss_assertions pss_assertions_i (.clk_i(clk_i), .rst_i(rst_i),
    .hard_soft_sleep_bit_pin(pss_if_i.hard_soft_sleep_bit_pin), .cs(pss_if_i.cs), .wr(pss_if_i.wr),
    .addr(pss_if_i.addr), .wdata(pss_if_i.wdata), .rdata(pss_if_i.rdata),
    .rx_window(pss_if_i.rx_window), .osc_enable_o(osc_enable_o),
    .current_sinks_on_o(current_sinks_on_o), .inputs_connected_o(inputs_connected_o),
    .irq_oe_o(irq_oe_o), .signal_monitor_out_o(signal_monitor_out_o),
    .antenna_drive_a_o(antenna_drive_a_o), .antenna_drive_b_o(antenna_drive_b_o),
    .osc_output_pin_o(osc_output_pin_o), .receiver_on_o(receiver_on_o),
    .linear_addressing_o(linear_addressing_o), .interface_detected_o(interface_detected_o),
    .init_addr_o(init_addr_o), .init_load_o(init_load_o));
  task automatic finish_test;
    $display("checks %0d mismatches %0d", samples_checked, fail_count);
    if (fail_count == 0 && samples_checked > 0) begin
      $display("RESULT: PASS");
    end else begin
      $display("RESULT: FAIL");
    end
    $finish;
  endtask
  task automatic check(input string name, input logic [31:0] seen, input logic [31:0] exp);
    samples_checked++;
    if (seen !== exp) begin
      fail_count++;
      $display("[ERR] %s expected %h seen %h", name, exp, seen);
    end
  endtask
  // Wishbone classic cycle; data taken at the acknowledging edge
  task automatic wb(input logic w, input logic [3:0] a, input logic [31:0] d, output logic [31:0] r);
    @(posedge clk_i);
    {cyc, stb, we, adr, dat_w} <= {1'b1, 1'b1, w, a, d};
    do @(posedge clk_i); while (ack !== 1'b1);
    r = dat_r;
    {cyc, stb, we} <= 3'b000;
  endtask
  // Parallel port access held four cycles
  task automatic lk(input logic w, input logic [5:0] a, input logic [7:0] d, output logic [31:0] r);
    @(posedge clk_i);
    {pss_if_b_i.cs, pss_if_b_i.wr, pss_if_b_i.addr, pss_if_b_i.wdata} <= {1'b1, w, a, d};
    repeat (4) @(posedge clk_i);
    r = {24'h0, pss_if_b_i.rdata};
    {pss_if_b_i.cs, pss_if_b_i.wr} <= 2'b00;
  endtask
  // Fixed pin levels while powered down
  task automatic pd_levels;
    check("drive_a", antenna_drive_a_o, 1'b1);
    check("drive_b", antenna_drive_b_o, 1'b0);
    check("osc_out", osc_output_pin_o, 1'b1);
    check("monitor", signal_monitor_out_o, 1'b0);
    check("irq_oe", irq_oe_o, 1'b0);
  endtask
  // Power-down source k held, released, then start-up timeline checked
  task automatic restart(input int k);
    @(posedge clk_i);
    {por_a, por_d, pd_b} <= 3'b001 << k;
    repeat (HARD_PD_MIN_CYCLES) @(posedge clk_i);
    check("osc_pd", b_osc, 1'b0);
    check("inputs_pd", b_inp, 1'b0);
    {por_a, por_d, pd_b} <= 3'b000;
    loads = 0;
    repeat (20) @(posedge clk_i);
    lk(0, ADDR_COMMAND, 8'h00, q);
    check("cmd_early", q[5:0], CMD_STARTUP);
    repeat (575) @(posedge clk_i);
    lk(0, ADDR_COMMAND, 8'h00, q);
    check("cmd_init", q[5:0], CMD_STARTUP);
    repeat (95) @(posedge clk_i);
    lk(0, ADDR_COMMAND, 8'h00, q);
    check("cmd_idle", q[5:0], CMD_IDLE);
    check("loads", loads, 32);
  endtask
  always @(posedge clk_i) begin
    loads += (b_load === 1'b1);
    cycles++;
    if (cycles == 30000) begin
      fail_count++;
      finish_test();
    end
  end
  initial begin
    {pss_if_b_i.cs, pss_if_b_i.wr, pss_if_b_i.addr, pss_if_b_i.wdata} = 16'h0;
    pss_if_b_i.rx_window = 1'b0;
    repeat (6) @(posedge clk_i);
    pd_levels();
    repeat (2) @(posedge clk_i);
    rst_i <= 1'b0;
    // Host end runs the whole handshake on the first link
    wb(1, WB_HCFG, 32'h1, q);
    wb(1, WB_HCTRL, 32'h1, q);
    repeat (200) @(posedge clk_i);
    pd_levels();
    check("osc_pd1", osc_enable_o, 1'b0);
    do wb(0, WB_HSTAT, 32'h0, q); while (q[2:0] != 3'd6 && q[2:0] != 3'd7);
    check("host_state", q, 32'h6);
    check("detected", interface_detected_o, 1'b1);
    check("linear", linear_addressing_o, 1'b1);
    check("rx_on", receiver_on_o, 1'b1);
    wb(0, 4'hc, 32'h0, q);
    check("unmapped", q, 32'h0);
    // Pin and both supply monitors each restart the second device
    for (int k = 0; k < 3; k++) begin
      restart(k);
    end
    lk(0, ADDR_RX_CTRL, 8'h00, q);
    check("auto_rst", q[RXCTRL_AUTO_GATE_BIT], 1'b1);
    check("rx_gated", b_rx, 1'b0);
    lk(1, ADDR_PAGE, PAGE_DETECT, q);
    lk(0, ADDR_COMMAND, 8'h00, q);
    check("cmd_detect", q[5:0], CMD_IDLE);
    check("det_b", b_det, 1'b1);
    lk(1, ADDR_PAGE, PAGE_LINEAR, q);
    check("lin_b", b_lin, 1'b1);
    pss_if_b_i.rx_window <= 1'b1;
    repeat (4) @(posedge clk_i);
    check("rx_win", b_rx, 1'b1);
    pss_if_b_i.rx_window <= 1'b0;
    lk(1, ADDR_RX_CTRL, 8'h00, q);
    check("rx_always", b_rx, 1'b1);
    // Sleep entry and its delayed exit
    lk(1, ADDR_CONTROL, 8'h10, q);
    check("sinks_sl", b_sinks, 1'b0);
    check("osc_sl", b_osc, 1'b0);
    check("inp_sl", b_inp, 1'b1);
    lk(1, ADDR_CONTROL, 8'h00, q);
    repeat (480) @(posedge clk_i);
    lk(0, ADDR_CONTROL, 8'h00, q);
    check("sleep_hold", q[CTRL_SLEEP_BIT], 1'b1);
    repeat (40) @(posedge clk_i);
    lk(0, ADDR_CONTROL, 8'h00, q);
    check("sleep_done", q[CTRL_SLEEP_BIT], 1'b0);
    // Standby leaves only after four oscillator edges
    lk(1, ADDR_CONTROL, 8'h20, q);
    check("dclk_sb", b_dclk, 1'b0);
    check("osc_sb", b_osc, 1'b1);
    lk(1, ADDR_CONTROL, 8'h00, q);
    for (int e = 1; e <= 4; e++) begin
      repeat (4) @(posedge clk_i);
      osc <= 1'b1;
      repeat (4) @(posedge clk_i);
      osc <= 1'b0;
      repeat (6) @(posedge clk_i);
      lk(0, ADDR_CONTROL, 8'h00, q);
      check("sb_bit", q[CTRL_STANDBY_BIT], e < 4);
    end
    // Power-down from standby aborts it and restarts
    lk(1, ADDR_CONTROL, 8'h20, q);
    restart(0);
    lk(0, ADDR_CONTROL, 8'h00, q);
    check("ctrl_clr", q[5:4], 2'b00);
    finish_test();
  end
endmodule
